// file: include/dif_defines.svh
// Constants for the DDR input strobe FIFO
`ifndef DIF_DEFINES_SVH
`define DIF_DEFINES_SVH

`define DIF_FIFO_AW      2
`define DIF_WORD_W       7
`define DIF_DCODE_W      8
`define DIF_NUM_PINS     8
`define DIF_RATIO_X2     3'd2
`define DIF_RATIO_X4     3'd4
`define DIF_RATIO_X7     3'd7
`define DIF_MASK_X2      7'h03
`define DIF_MASK_X4      7'h0F
`define DIF_MASK_X7      7'h7F

`endif

// file: include/dif_pkg.sv
// Types shared by the DDR input strobe FIFO modules
`include "dif_defines.svh"

package dif_pkg;

  typedef enum logic [1:0] {
    DIF_GEAR_X2,
    DIF_GEAR_X4,
    DIF_GEAR_X7
  } dif_gear_e;

  // Pointer bundle sent from the group control unit to every pin
  typedef struct packed {
    logic                     wr_en;
    logic                     rd_en;
    logic [`DIF_FIFO_AW-1:0]  wr_addr;
    logic [`DIF_FIFO_AW-1:0]  rd_addr;
    logic                     full;
    logic                     empty;
  } dif_ptr_s;

  function automatic logic [2:0] dif_ratio(input dif_gear_e m);
    case (m)
      DIF_GEAR_X2: dif_ratio = `DIF_RATIO_X2;
      DIF_GEAR_X4: dif_ratio = `DIF_RATIO_X4;
      default:     dif_ratio = `DIF_RATIO_X7;
    endcase
  endfunction : dif_ratio

  function automatic logic [`DIF_WORD_W-1:0] dif_mask(input dif_gear_e m);
    case (m)
      DIF_GEAR_X2: dif_mask = `DIF_MASK_X2;
      DIF_GEAR_X4: dif_mask = `DIF_MASK_X4;
      default:     dif_mask = `DIF_MASK_X7;
    endcase
  endfunction : dif_mask

endpackage : dif_pkg

// file: hdl/dif_ptr_ctrl.sv
// Group pointer control unit for the input FIFOs
`timescale 1ns/1ps
`include "dif_defines.svh"

module dif_ptr_ctrl (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             wr_req,
  input  wire logic             rd_req,
  output dif_pkg::dif_ptr_s     ptr
);
  import dif_pkg::*;

  localparam int AW = `DIF_FIFO_AW;

  logic [AW:0] wr_bin_q;
  logic [AW:0] rd_bin_q;
  logic [AW:0] wr_gray_q;
  logic [AW:0] rd_gray_q;
  logic        full;
  logic        empty;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  assign empty = (wr_gray_q == rd_gray_q);
  assign full  = (wr_gray_q == {~rd_gray_q[AW:AW-1], rd_gray_q[AW-2:0]});

  assign ptr.wr_en   = wr_req & ~full;
  assign ptr.rd_en   = rd_req & ~empty;
  assign ptr.wr_addr = wr_bin_q[AW-1:0];
  assign ptr.rd_addr = rd_bin_q[AW-1:0];
  assign ptr.full    = full;
  assign ptr.empty   = empty;

  // ----------------------------------------
  // Write pointer
  // ----------------------------------------
  // joint clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_bin_q  <= '0;
      wr_gray_q <= '0;
    end else if (ptr.wr_en) begin
      wr_bin_q  <= wr_bin_q + 1'b1;
      wr_gray_q <= bin2gray(wr_bin_q + 1'b1);
    end
  end

  // ----------------------------------------
  // Read pointer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_bin_q  <= '0;
      rd_gray_q <= '0;
    end else if (ptr.rd_en) begin
      rd_bin_q  <= rd_bin_q + 1'b1;
      rd_gray_q <= bin2gray(rd_bin_q + 1'b1);
    end
  end

  AST_RESET_EMPTY: assert property (@(posedge clk) sys_rst |=> empty && wr_bin_q == '0 && rd_bin_q == '0)
    else $error("pointers not cleared by reset");
  AST_GRAY_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    $countones(wr_gray_q ^ $past(wr_gray_q)) <= 1 && $countones(rd_gray_q ^ $past(rd_gray_q)) <= 1)
    else $error("gray pointer changed more than one bit");
  AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_bin_q - rd_bin_q) <= (AW+1)'(1 << AW))
    else $error("write while full");

endmodule : dif_ptr_ctrl

// file: hdl/dif_top.sv
// DDR input strobe FIFO with gearing for one strobe group
`timescale 1ns/1ps
`include "dif_defines.svh"

module dif_top #(
  parameter int NUM_PINS = `DIF_NUM_PINS
) (
  input  wire logic                               clk,
  input  wire logic                               sys_rst,
  input  wire logic                               strobe_in,
  input  wire logic                               fast_edge_clock,
  input  wire logic [NUM_PINS-1:0]                data_in,
  input  wire logic [`DIF_DCODE_W-1:0]            delay_code,
  input  wire logic                               delay_lock,
  input  dif_pkg::dif_gear_e                      gear_mode,
  input  wire logic                               word_align_request,
  output logic [NUM_PINS-1:0][`DIF_WORD_W-1:0]    q_word,
  output logic                                    q_valid,
  output logic                                    overflow
);
  import dif_pkg::*;

  localparam int DEPTH = 1 << `DIF_FIFO_AW;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [NUM_PINS-1:0] data_s1_q;
  logic [NUM_PINS-1:0] data_s2_q;
  logic [2:0]          stb_q;
  logic [2:0]          fast_edge_clock_q;
  logic [1:0]          lock_q;
  logic                stb_edge;
  logic                fast_edge_clock_edge;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_s1_q <= '0;
      data_s2_q <= '0;
      lock_q    <= '0;
    end else begin
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
      lock_q    <= {lock_q[0], delay_lock};
    end
  end

  // No reset: the chains keep tracking the pins, so leaving reset shows no false edge
  always_ff @(posedge clk) begin
    stb_q  <= {stb_q[1:0], strobe_in};
    fast_edge_clock_q <= {fast_edge_clock_q[1:0], fast_edge_clock};
  end

  // Both edges count: data is double rate
  assign stb_edge  = stb_q[2] ^ stb_q[1];
  assign fast_edge_clock_edge = fast_edge_clock_q[2] ^ fast_edge_clock_q[1];

  // ----------------------------------------
  // Strobe delay
  // ----------------------------------------
  logic [`DIF_DCODE_W-1:0] dly_cnt_q;
  logic                    dly_busy_q;
  logic                    dly_fire;

  assign dly_fire = dly_busy_q && (dly_cnt_q == '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dly_cnt_q  <= '0;
      dly_busy_q <= 1'b0;
    end else if (stb_edge && lock_q[1]) begin
      dly_cnt_q  <= delay_code;
      dly_busy_q <= 1'b1;
    end else if (dly_fire) begin
      dly_busy_q <= 1'b0;
    end else if (dly_busy_q) begin
      dly_cnt_q  <= dly_cnt_q - 1'b1;
    end
  end

  // ----------------------------------------
  // Pointer control and FIFO storage
  // ----------------------------------------
  dif_ptr_s ptr;

  dif_ptr_ctrl u_ptr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_req  (dly_fire),
    .rd_req  (fast_edge_clock_edge),
    .ptr     (ptr)
  );

  logic [NUM_PINS-1:0] mem_q [DEPTH];
  logic [NUM_PINS-1:0] rd_bits;

  always_ff @(posedge clk) begin
    if (ptr.wr_en) begin
      mem_q[ptr.wr_addr] <= data_s2_q;
    end
  end

  assign rd_bits = mem_q[ptr.rd_addr];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overflow <= 1'b0;
    end else if (dly_fire && ptr.full) begin
      overflow <= 1'b1;
    end
  end

  // ----------------------------------------
  // Gearing
  // ----------------------------------------
  logic [NUM_PINS-1:0][`DIF_WORD_W-1:0] sr_q;
  logic [2:0]                           bit_cnt_q;
  logic                                 align_pend_q;
  logic                                 word_done;

  assign word_done = ptr.rd_en && !align_pend_q && (bit_cnt_q == dif_ratio(gear_mode) - 3'd1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      align_pend_q <= 1'b0;
    end else if (word_align_request) begin
      align_pend_q <= 1'b1;
    end else if (ptr.rd_en) begin
      align_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr_q      <= '0;
      bit_cnt_q <= '0;
    end else if (ptr.rd_en) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        sr_q[p] <= {sr_q[p][`DIF_WORD_W-2:0], rd_bits[p]};
      end
      if (align_pend_q) begin
        bit_cnt_q <= bit_cnt_q;
      end else if (word_done) begin
        bit_cnt_q <= '0;
      end else begin
        bit_cnt_q <= bit_cnt_q + 3'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_word  <= '0;
      q_valid <= 1'b0;
    end else begin
      q_valid <= word_done;
      if (word_done) begin
        for (int p = 0; p < NUM_PINS; p++) begin
          q_word[p] <= {sr_q[p][`DIF_WORD_W-2:0], rd_bits[p]} & dif_mask(gear_mode);
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Cycles since the last accepted strobe edge, for the write timing check
  logic [`DIF_DCODE_W-1:0] age_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      age_q <= '0;
    end else if (stb_edge && lock_q[1]) begin
      age_q <= '0;
    end else if (age_q != '1) begin
      age_q <= age_q + 1'b1;
    end
  end

  AST_WR_ON_STROBE: assert property (@(posedge clk) disable iff (sys_rst) ptr.wr_en |-> age_q == delay_code)
    else $error("write not tied to delayed strobe");
  AST_DELAY_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    (stb_edge && lock_q[1]) |=> dly_busy_q && dly_cnt_q == $past(delay_code))
    else $error("delay counter not loaded from delay code");
  AST_RD_ON_FAST_EDGE_CLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    ptr.rd_en |=> ptr.rd_addr == $past(ptr.rd_addr) + 1'b1 && sr_q[0][0] == $past(rd_bits[0]))
    else $error("read not tied to edge clock");
  AST_NO_UNDERFLOW: assert property (@(posedge clk) disable iff (sys_rst) ptr.empty |=> $stable(sr_q))
    else $error("gearing read from empty FIFO");
  AST_PIN_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst)
    ptr.wr_en |=> mem_q[$past(ptr.wr_addr)] == $past(data_s2_q))
    else $error("pin data not stored");
  AST_WORD_MASK: assert property (@(posedge clk) disable iff (sys_rst)
    q_valid |-> (q_word[0] & ~dif_mask(gear_mode)) == '0)
    else $error("word wider than ratio");
  AST_GEAR_RESET: assert property (@(posedge clk) sys_rst |=> !q_valid && bit_cnt_q == '0 && !dly_busy_q)
    else $error("gearing not reset");

endmodule : dif_top

// file: test/dif_mem_model.sv
// Memory-side model driving strobe and data
`timescale 1ns/1ps
module dif_mem_model (
  output logic       strobe_in,
  output logic [7:0] data_in
);
  initial begin
    strobe_in = 1'b0;
    data_in   = 8'h00;
  end
  task automatic send_bit(input logic [7:0] d);
    data_in   <= d;
    strobe_in <= ~strobe_in;
    #62.5;
  endtask : send_bit
  // Released bus shows inverted data, strobe stands still
  task automatic release_bus();
    data_in <= ~data_in;
  endtask : release_bus
endmodule : dif_mem_model

// file: test/dif_top_test.sv
// Self-checking bench for the DDR input strobe FIFO
`timescale 1ns/1ps
module dif_top_test;
  import dif_pkg::*;
  typedef logic [7:0][6:0] dif_word_t;
  logic clk = 1'b0, sys_rst = 1'b1, fast_edge_clock = 1'b0, fast_edge_clock_run = 1'b1;
  logic delay_lock = 1'b0, word_align_request = 1'b0, strobe_in, q_valid, overflow;
  logic [7:0] delay_code = 8'h02, data_in;
  dif_gear_e gear_mode = DIF_GEAR_X2;
  dif_word_t q_word;
  dif_word_t exp_q[$];
  int failures = 0, num_checks = 0;
  logic [31:0] lfsr_q = 32'h5d37_fd3f;

  always #5 clk = ~clk;
  // edge clock free-running at strobe rate
  always begin
    #62.5;
    if (fast_edge_clock_run) fast_edge_clock <= ~fast_edge_clock;
  end

  dif_top dut (.clk(clk), .sys_rst(sys_rst), .strobe_in(strobe_in), .fast_edge_clock(fast_edge_clock),
    .data_in(data_in), .delay_code(delay_code), .delay_lock(delay_lock), .gear_mode(gear_mode),
    .word_align_request(word_align_request), .q_word(q_word), .q_valid(q_valid), .overflow(overflow));
  dif_mem_model mem (.strobe_in(strobe_in), .data_in(data_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    exp_q.delete();
    repeat (4) @(posedge clk);
  endtask : do_reset

  // Words noted before sending; lead adds one bit the align slip eats
  task automatic burst(input int nwords, input bit lead);
    int r;
    dif_word_t w;
    logic [7:0] d[7];
    r = (gear_mode == DIF_GEAR_X2) ? 2 : (gear_mode == DIF_GEAR_X4) ? 4 : 7;
    if (lead) begin
      lfsr_q = lfsr_next(lfsr_q);
      mem.send_bit(lfsr_q[7:0]);
    end
    for (int i = 0; i < nwords; i++) begin
      w = '0;
      for (int b = 0; b < r; b++) begin
        lfsr_q = lfsr_next(lfsr_q);
        d[b] = lfsr_q[7:0];
        for (int p = 0; p < 8; p++) w[p][r-1-b] = d[b][p];
      end
      exp_q.push_back(w);
      for (int b = 0; b < r; b++) mem.send_bit(d[b]);
    end
    mem.release_bus();
  endtask : burst

  task automatic drain(input string name);
    int n;
    for (n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge clk);
    if (exp_q.size() != 0) begin
      failures++;
      $display("FAIL t=%0t words missing", $time);
      conclude();
    end
    repeat (40) @(posedge clk);
    $display("test %s done", name);
  endtask : drain

  // ------------------------------------------------------------
  // Output watcher
  // ------------------------------------------------------------
  always @(negedge clk) begin
    if (!sys_rst && q_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("FAIL t=%0t unexpected word", $time);
      end else check({8'h00, q_word}, {8'h00, exp_q.pop_front()});
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    check({6'h00, q_word, q_valid, overflow}, 64'h0);
    // Strobe edges ignored until the delay code is locked
    for (int i = 0; i < 8; i++) mem.send_bit(8'h5a ^ i[7:0]);
    mem.release_bus();
    drain("unlocked");
    @(posedge clk);
    delay_lock <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      gear_mode <= dif_gear_e'(m);
      do_reset();
      burst(3, 1'b0);
      drain("gearing");
      @(posedge clk);
      word_align_request <= 1'b1;
      @(posedge clk);
      word_align_request <= 1'b0;
      burst(2, 1'b1);
      drain("align");
    end
    // Edge clock stalled: the fifth write finds the FIFO full
    fast_edge_clock_run = 1'b0;
    for (int i = 0; i < 6; i++) mem.send_bit(8'hc3);
    mem.release_bus();
    repeat (30) @(posedge clk);
    check({63'h0, overflow}, 64'h1);
    $display("test overflow done");
    do_reset();
    check({63'h0, overflow}, 64'h0);
    fast_edge_clock_run = 1'b1;
    burst(1, 1'b0);
    drain("restart");
    conclude();
  end
endmodule : dif_top_test
